//--- core/bst_timing.sv
// back-emf sense sequencer and overdrive clamp timer with avalon registers
//
// Function
// RULE1: settle delay from 4-bit code before sampling
// RULE2: discharge delay from second code, same table
// RULE3: 2-bit clamp code: off, 25/50/100 ms
// RULE4: clamp expiry limits output to rated level
// RULE5: clamp fires on time, not zero crossing
// RULE6: calibration or diagnostics ignore clamp code
// RULE7: calibration always uses automatic overdrive
// RULE8: sample offset wait around crossing, 2-bit code
// RULE9: crossing detect window from 2-bit code
// RULE10: stop drive, discharge, settle, then sample
`timescale 1ns/1ps
`default_nettype none
module bst_timing #(
   parameter int P_MS_CYC = bst_pkg::MS_CYC     // cycles per millisecond
)(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   input  wire logic [9:0]  i_avs_address,      // byte address
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_lra_mode,         // 1 resonant, 0 eccentric mass
   input  wire logic        i_meas_start,       // pulse: begin a measurement
   input  wire logic        i_zero_cross,       // async comparator level
   input  wire logic        i_od_active,        // overdrive or braking period
   input  wire logic        i_cal_active,       // auto-calibration running
   input  wire logic        i_diag_active,      // diagnostics running
   output logic             o_drive_off,        // output stage released
   output logic             o_adc_start,        // pulse: convert back-emf
   output logic             o_rated_clamp,      // clamp to rated voltage
   output logic             o_auto_od           // automatic overdrive in use
);
   localparam int MW = $clog2(P_MS_CYC);
   localparam logic [MW-1:0] MS_LAST = MW'(P_MS_CYC - 1);

   // delay lookup shared by settle and discharge timing
   function automatic logic [8:0] bemf_us(input logic [3:0] code,
                                          input logic lra);
      logic [8:0] v;
      v = bst_pkg::LRA_US[code];
      if (!lra)
      begin
         // eccentric mass has no entry above 3: hold the longest one
         v = (code > 4'h3) ? bst_pkg::ERM_US[3] : bst_pkg::ERM_US[code[1:0]];
      end
      return v;
   endfunction

   // register state
   logic [7:0]          settle_r;           // settle and discharge codes
   logic [7:0]          odsamp_r;           // clamp, sample, window codes
   bst_pkg::bst_cfg_t   cfg;                // decoded fields
   // sequencer state
   bst_pkg::bst_state_t st_r;
   bst_pkg::bst_state_t st_nxt;
   logic [bst_pkg::US_W-1:0] div_r;         // cycles within a microsecond
   logic [8:0]          us_r;               // microseconds in this state
   logic                zc_meta_r;          // synchroniser first stage
   logic                zc_sync_r;          // synchroniser second stage
   logic                zc_dly_r;           // edge detect history
   logic                zc_seen_r;          // crossing found in window
   logic                tout_r;             // window ran out
   // clamp timer
   logic [MW-1:0]       mdiv_r;             // cycles within a millisecond
   logic [6:0]          ms_r;               // milliseconds of overdrive

   assign cfg.settle = settle_r[bst_pkg::F_SETTLE +: 4];
   assign cfg.disch  = settle_r[bst_pkg::F_DISCH +: 4];
   assign cfg.od     = odsamp_r[bst_pkg::F_OD +: 2];
   assign cfg.samp   = odsamp_r[bst_pkg::F_SAMP +: 2];
   assign cfg.zcw    = odsamp_r[bst_pkg::F_ZCW +: 2];

   // bus decode
   wire       req     = i_avs_read | i_avs_write;
   wire       sel_a   = i_avs_address == bst_pkg::ADR_SETTLE;
   wire       sel_b   = i_avs_address == bst_pkg::ADR_ODSAMP;
   wire       sel_s   = i_avs_address == bst_pkg::ADR_STATUS;
   // a write lands only at the edge where waitrequest is seen low
   wire       wr_go   = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
   wire [7:0] status  = {4'h0, tout_r, zc_seen_r, o_rated_clamp, o_drive_off};
   // unmapped addresses read zero and still complete
   wire [7:0] rd_mux  = sel_a ? settle_r :
                        sel_b ? odsamp_r :
                        sel_s ? status : 8'h00;

   // avalon slave: one wait cycle, then a single answer cycle
   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h0000_0000;
      end
      else if (req && o_avs_waitrequest)
      begin
         o_avs_waitrequest <= 1'b0;
         o_avs_readdata    <= {24'h00_0000, rd_mux};
      end
      else
      begin
         o_avs_waitrequest <= 1'b1;
      end
   end

   // configuration registers; reserved bits always read zero
   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         settle_r <= bst_pkg::RST_SETTLE;
         odsamp_r <= bst_pkg::RST_ODSAMP;
      end
      else if (wr_go && sel_a)
      begin
         settle_r <= i_avs_writedata[7:0];
      end
      else if (wr_go && sel_b)
      begin
         odsamp_r <= {2'h0, i_avs_writedata[bst_pkg::F_RSV-1:0]};
      end
   end

   // comparator crossing: two stages before anything reads it
   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         zc_meta_r <= 1'b0;
         zc_sync_r <= 1'b0;
         zc_dly_r  <= 1'b0;
      end
      else
      begin
         zc_meta_r <= i_zero_cross;
         zc_sync_r <= zc_meta_r;
         zc_dly_r  <= zc_sync_r;
      end
   end

   // either polarity of the comparator counts as a crossing
   wire zc_edge = zc_sync_r ^ zc_dly_r;

   // per-state target time in microseconds
   wire [8:0] disch_us  = bemf_us(cfg.disch, i_lra_mode);   // [RULE2]
   wire [8:0] settle_us = bemf_us(cfg.settle, i_lra_mode);  // [RULE1]
   wire [8:0] zcw_us    = bst_pkg::ZCW_US[cfg.zcw];         // [RULE9]
   wire [8:0] samp_us   = bst_pkg::SAMP_US[cfg.samp];       // [RULE8]
   wire [8:0] tgt_us    = (st_r == bst_pkg::ST_DISCH)  ? disch_us  :
                          (st_r == bst_pkg::ST_SETTLE) ? settle_us :
                          (st_r == bst_pkg::ST_ZCWAIT) ? zcw_us    : samp_us;
   wire       us_tick   = div_r == bst_pkg::US_LAST;
   // >= so that a code lowered mid-phase ends it at the next microsecond tick, no wrap
   wire       ph_done   = us_tick & (us_r >= tgt_us - 9'h001);
   // convert request: last cycle of the sample offset
   wire       adc_go    = (st_r == bst_pkg::ST_SAMPLE) & ph_done;

   // measurement order: release drive, discharge, settle, find, sample
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         bst_pkg::ST_IDLE:
            if (i_meas_start)
               st_nxt = bst_pkg::ST_DISCH;                 // [RULE10]
         bst_pkg::ST_DISCH:
            if (ph_done)
               st_nxt = bst_pkg::ST_SETTLE;                // [RULE2]
         bst_pkg::ST_SETTLE:
            if (ph_done)
               st_nxt = bst_pkg::ST_ZCWAIT;                // [RULE1]
         bst_pkg::ST_ZCWAIT:
            if (zc_edge || ph_done)
               st_nxt = bst_pkg::ST_SAMPLE;                // [RULE9]
         bst_pkg::ST_SAMPLE:
            if (ph_done)
               st_nxt = bst_pkg::ST_IDLE;                  // [RULE8]
         default:
            st_nxt = bst_pkg::ST_IDLE;
      endcase
   end

   // sequencer registers; the time base restarts on every state change
   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         st_r        <= bst_pkg::ST_IDLE;
         div_r       <= '0;
         us_r        <= 9'h000;
         o_drive_off <= 1'b0;
         o_adc_start <= 1'b0;
         zc_seen_r   <= 1'b0;
         tout_r      <= 1'b0;
      end
      else
      begin
         st_r        <= st_nxt;
         div_r       <= (st_nxt != st_r || us_tick) ? '0 : div_r + 1'b1;
         us_r        <= (st_nxt != st_r) ? 9'h000 : us_r + {8'h00, us_tick};
         // drive stays released through the convert pulse: the adc must see a quiet winding
         o_drive_off <= (st_nxt != bst_pkg::ST_IDLE) || adc_go; // [RULE10]
         o_adc_start <= adc_go;                           // [RULE10]
         if (st_r == bst_pkg::ST_IDLE && i_meas_start)
         begin
            zc_seen_r <= 1'b0;
            tout_r    <= 1'b0;
         end
         else if (st_r == bst_pkg::ST_ZCWAIT && zc_edge)
         begin
            zc_seen_r <= 1'b1;
         end
         else if (st_r == bst_pkg::ST_ZCWAIT && ph_done)
         begin
            tout_r <= 1'b1;                                // [RULE9]
         end
      end
   end

   // overdrive clamp timer
   wire       od_ign  = i_cal_active | i_diag_active;      // [RULE6]
   wire       od_en   = (cfg.od != 2'h0) & ~od_ign;        // [RULE3]
   wire       od_on   = od_en & i_od_active;
   wire [6:0] od_lim  = bst_pkg::OD_MS[cfg.od];            // [RULE3]
   wire       ms_hit  = od_on & (ms_r >= od_lim);          // [RULE4]
   wire       ms_tick = mdiv_r == MS_LAST;

   // counts only while overdrive or braking runs; no crossing gate
   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         mdiv_r        <= '0;
         ms_r          <= 7'h00;
         o_rated_clamp <= 1'b0;
         o_auto_od     <= 1'b1;
      end
      else
      begin
         if (!od_on)
         begin
            mdiv_r <= '0;
            ms_r   <= 7'h00;
         end
         else if (!ms_hit)
         begin
            mdiv_r <= ms_tick ? '0 : mdiv_r + 1'b1;
            ms_r   <= ms_r + {6'h00, ms_tick};
         end
         o_rated_clamp <= ms_hit;                          // [RULE4] [RULE5]
         o_auto_od     <= ~od_en;                          // [RULE7]
      end
   end

   // checks
   a_settle_time: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE1]
      (st_r == bst_pkg::ST_SETTLE && st_nxt == bst_pkg::ST_ZCWAIT)
      |-> us_tick && us_r + 9'h001 >= settle_us)
      else $error("settle phase ended early");
   a_disch_time: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE2]
      (st_r == bst_pkg::ST_DISCH && st_nxt == bst_pkg::ST_SETTLE)
      |-> us_tick && us_r + 9'h001 >= disch_us)
      else $error("discharge phase ended early");
   a_clamp_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE3]
      cfg.od == 2'h0 |=> !o_rated_clamp && o_auto_od)
      else $error("clamp active with code zero");
   a_clamp_fire: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE4]
      (od_on && ms_r >= od_lim) |=> o_rated_clamp)
      else $error("clamp missed expiry");
   a_clamp_timed: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE5]
      $rose(o_rated_clamp) |-> $past(od_on) && $past(ms_r) >= $past(od_lim))
      else $error("clamp rose without timer expiry");
   a_cal_ignore: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE6]
      (i_cal_active || i_diag_active) |=> !o_rated_clamp)
      else $error("clamp during calibration or diagnostics");
   a_cal_auto: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE7]
      i_cal_active |=> o_auto_od)
      else $error("calibration without automatic overdrive");
   a_sample_time: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE8]
      $rose(o_adc_start) |-> $past(us_r) + 9'h001 >= $past(samp_us))
      else $error("sample offset too short");
   a_zc_window: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE9]
      (st_r == bst_pkg::ST_ZCWAIT && !zc_edge && !us_tick)
      |=> st_r == bst_pkg::ST_ZCWAIT)
      else $error("window left without crossing or expiry");
   a_meas_order: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE10]
      (st_r == bst_pkg::ST_IDLE && i_meas_start)
      |=> o_drive_off && st_r == bst_pkg::ST_DISCH && !o_adc_start)
      else $error("measurement did not begin with discharge");
   a_adc_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE10]
      o_adc_start |-> o_drive_off ##1 !o_adc_start)
      else $error("convert pulse without drive released or too long");
   a_zc_exit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE9]
      (st_r == bst_pkg::ST_ZCWAIT && zc_edge)
      |=> st_r == bst_pkg::ST_SAMPLE && zc_seen_r)
      else $error("crossing did not end the window");
endmodule // bst_timing
`default_nettype wire

//--- core/bst_pkg.sv
// constants, tables and types for the back-emf sense timing block
package bst_pkg;
   // clock and time units
   localparam int CLK_NS  = 20;                            // 50 MHz period
   localparam int T_US_NS = 1000;                          // one microsecond
   localparam int T_MS_US = 1000;                          // one millisecond
   localparam int US_CYC  = (T_US_NS + CLK_NS - 1) / CLK_NS;
   localparam int US_W    = $clog2(US_CYC);
   localparam int MS_CYC  = T_MS_US * US_CYC;              // above 4096: module param
   localparam logic [US_W-1:0] US_LAST = US_W'(US_CYC - 1);
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SETTLE = 8'h28;
   localparam logic [7:0] IDX_ODSAMP = 8'h29;
   localparam logic [7:0] IDX_STATUS = 8'h30;
   localparam logic [9:0] ADR_SETTLE = {IDX_SETTLE, 2'h0};
   localparam logic [9:0] ADR_ODSAMP = {IDX_ODSAMP, 2'h0};
   localparam logic [9:0] ADR_STATUS = {IDX_STATUS, 2'h0};
   // reset values
   localparam logic [7:0] RST_SETTLE = 8'h11;
   localparam logic [7:0] RST_ODSAMP = 8'h0C;
   // field positions
   localparam int F_SETTLE = 4;
   localparam int F_DISCH  = 0;
   localparam int F_OD     = 4;
   localparam int F_SAMP   = 2;
   localparam int F_ZCW    = 0;
   localparam int F_RSV    = 6;
   // delay tables in microseconds, clamp table OD_MS in milliseconds, index is the code
   localparam logic [8:0] LRA_US [16] = '{9'h00F, 9'h019, 9'h032, 9'h04B,
      9'h05A, 9'h069, 9'h078, 9'h087, 9'h096, 9'h0A5, 9'h0B4, 9'h0C3,
      9'h0D2, 9'h0EB, 9'h104, 9'h11D};
   localparam logic [8:0] ERM_US [4]  = '{9'h02D, 9'h04B, 9'h096, 9'h0E1};
   localparam logic [8:0] SAMP_US [4] = '{9'h096, 9'h0C8, 9'h0FA, 9'h12C};
   localparam logic [8:0] ZCW_US [4]  = '{9'h064, 9'h0C8, 9'h12C, 9'h186};
   localparam logic [6:0] OD_MS [4]   = '{7'h00, 7'h19, 7'h32, 7'h64};
   // measurement sequencer states, gray along the path except the SAMPLE to IDLE return (two bits)
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_DISCH  = 3'h1,
      ST_SETTLE = 3'h3,
      ST_ZCWAIT = 3'h2,
      ST_SAMPLE = 3'h6
   } bst_state_t;
   // decoded configuration fields
   typedef struct packed {
      logic [3:0] settle;
      logic [3:0] disch;
      logic [1:0] od;
      logic [1:0] samp;
      logic [1:0] zcw;
   } bst_cfg_t;
endpackage

//--- sim/bst_actuator_model.sv
// actuator model: back-emf comparator that flips a set time after drive release
`timescale 1ns/1ps
`default_nettype none
module bst_actuator_model (
   input  wire logic        i_clk,
   input  wire logic        i_drive_off,   // output stage released
   input  wire logic [15:0] i_cross_dly,   // cycles to crossing, 0 never
   output logic             o_zero_cross   // comparator level
);
   logic [15:0] cnt_r;                     // cycles since release
   initial cnt_r = 16'h0000;
   initial o_zero_cross = 1'b0;
   // one flip per release; a winding crosses once per half period, not on every cycle
   always @(posedge i_clk)
   begin
      if (!i_drive_off)
         cnt_r <= 16'h0000;
      else
         cnt_r <= cnt_r + 16'h0001;
      if (i_drive_off && i_cross_dly != 16'h0000 && cnt_r == i_cross_dly)
         o_zero_cross <= ~o_zero_cross;
   end
endmodule // bst_actuator_model
`default_nettype wire

//--- sim/bst_timing_tb_top.sv
// testbench for the back-emf sense timing block
`timescale 1ns/1ps
`default_nettype none
module bst_timing_tb_top;
   logic        clk = 1'b0;        // 50 MHz
   logic        rst_b = 1'b0;      // active low reset
   logic [9:0]  adr = 10'h000;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [3:0]  be = 4'h0;
   logic        lra = 1'b1;
   logic        start = 1'b0;
   logic        od = 1'b0;
   logic        cal = 1'b0;
   logic        diag = 1'b0;
   logic [15:0] dly = 16'h0000;    // model crossing delay
   wire  [31:0] rdata;
   wire         wait_r, zc, doff, adc, clamp, auto_od;
   int          cyc = 0;           // free cycle counter
   int          err_count = 0;
   int          compares = 0;
   int          ms_tab [4] = '{0, 25, 50, 100};
   logic [31:0] q;
   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   bst_timing #(.P_MS_CYC(50)) i_bst_timing (.i_ref_clk(clk), .i_rst_b(rst_b),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
      .i_lra_mode(lra), .i_meas_start(start), .i_zero_cross(zc), .i_od_active(od),
      .i_cal_active(cal), .i_diag_active(diag), .o_drive_off(doff), .o_adc_start(adc),
      .o_rated_clamp(clamp), .o_auto_od(auto_od));
   bst_actuator_model i_bst_actuator_model (.i_clk(clk), .i_drive_off(doff),
      .i_cross_dly(dly), .o_zero_cross(zc));
   task automatic stop_test();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
      compares++;
      if (g < lo || g > hi)
      begin
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
         err_count++;
      end
   endtask
   // one avalon transfer; hold everything until waitrequest is sampled low
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] b, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      rd <= ~w;
      wr <= w;
      wd <= {24'h0, d};
      be <= b;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wait_r !== 1'b0 && n < 50);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50)
         chk("waitrequest", 32'h0, 32'h1);
   endtask
   // one measurement; delay counted from drive release to the convert pulse
   task automatic meas(input logic l, input logic [7:0] r28, input logic [15:0] cd,
                       input int lo, input int hi, input logic [7:0] st);
      int t0, n;
      lra <= l;
      dly <= cd;
      bus(1'b1, bst_pkg::ADR_SETTLE, r28, 4'hF, q);
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      while (doff !== 1'b1 && n < 10)
      begin
         @(posedge clk);
         n++;
      end
      t0 = cyc;
      bus(1'b0, bst_pkg::ADR_STATUS, 8'h00, 4'hF, q);
      chk("busy", 32'h1, {31'h0, q[0]});
      n = 0;
      while (adc !== 1'b1 && n < 30000)
      begin
         @(posedge clk);
         n++;
      end
      chk_rng("adc delay", lo, hi, cyc - t0);
      chk("drive off at adc", 32'h1, {31'h0, doff});
      repeat (2) @(posedge clk);
      chk("drive off after", 32'h0, {31'h0, doff});
      bus(1'b0, bst_pkg::ADR_STATUS, 8'h00, 4'hF, q);
      chk("status after", {24'h0, st}, q);
   endtask
   initial
   begin
      #1600000;
      err_count++;
      stop_test();
   end
   initial
   begin
      int n;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      chk("auto od reset", 32'h1, {31'h0, auto_od});
      bus(1'b0, bst_pkg::ADR_SETTLE, 8'h00, 4'hF, q);
      chk("settle reset", 32'h11, q);
      bus(1'b0, bst_pkg::ADR_ODSAMP, 8'h00, 4'hF, q);
      chk("odsamp reset", 32'h0C, q);
      bus(1'b0, 10'h3FC, 8'h00, 4'hF, q);
      chk("unmapped", 32'h0, q);
      bus(1'b1, bst_pkg::ADR_ODSAMP, 8'hFF, 4'hF, q);
      bus(1'b1, bst_pkg::ADR_ODSAMP, 8'h00, 4'hE, q);
      bus(1'b0, bst_pkg::ADR_ODSAMP, 8'h00, 4'hF, q);
      chk("reserved and byteenable", 32'h3F, q);
      bus(1'b1, bst_pkg::ADR_ODSAMP, 8'h00, 4'hF, q);
      // resonant, shortest codes, no crossing: 15+15+100+150 us
      meas(1'b1, 8'h00, 16'h0000, 13998, 14003, 8'h08);
      // sample code 1 at 200 us, window code 3 at 390 us
      bus(1'b1, bst_pkg::ADR_ODSAMP, 8'h07, 4'hF, q);
      // eccentric, settle code 4 at 225 us, discharge 75 us, crossing cuts the window
      meas(1'b0, 8'h41, 16'd15500, 25498, 25510, 8'h04);
      // clamp codes 1 to 3 with no crossing at all
      for (int c = 1; c < 4; c++)
      begin
         bus(1'b1, bst_pkg::ADR_ODSAMP, 8'(c << 4), 4'hF, q);
         @(posedge clk);
         od <= 1'b1;
         n = 0;
         do
         begin
            @(posedge clk);
            n++;
         end
         while (clamp !== 1'b1 && n < 6000);
         chk_rng("clamp time", ms_tab[c] * 50, ms_tab[c] * 50 + 3, n);
         chk("auto od clamped", 32'h0, {31'h0, auto_od});
         od <= 1'b0;
         repeat (3) @(posedge clk);
         chk("clamp release", 32'h0, {31'h0, clamp});
      end
      // code 0, then calibration, then diagnostics with code 1
      for (int k = 0; k < 3; k++)
      begin
         bus(1'b1, bst_pkg::ADR_ODSAMP, (k == 0) ? 8'h00 : 8'h10, 4'hF, q);
         @(posedge clk);
         cal <= (k == 1);
         diag <= (k == 2);
         od <= 1'b1;
         repeat (1400) @(posedge clk);
         chk("no clamp", 32'h0, {31'h0, clamp});
         chk("auto od kept", 32'h1, {31'h0, auto_od});
         od <= 1'b0;
         cal <= 1'b0;
         diag <= 1'b0;
      end
      stop_test();
   end
endmodule // bst_timing_tb_top
`default_nettype wire
